/* include/pmdp_pkg.sv */
// Constants and carrier types of the MII data path of a 10/100 PHY.
// Assumes a 40 MHz reference clock and a line-side logic on its own clock.
package pmdp_pkg;

  // Reference clock and MII clock rates
  localparam int REF_HZ     = 40_000_000;
  localparam int RATE10_HZ  = 2_500_000;
  localparam int RATE100_HZ = 25_000_000;

  // Half periods of the MII clocks in reference cycles, rounded down, at least one
  localparam int HALF10_RAW  = REF_HZ / (2 * RATE10_HZ);
  localparam int HALF100_RAW = REF_HZ / (2 * RATE100_HZ);
  localparam int CW          = 8;
  localparam logic [CW-1:0] HALF10_CNT  = CW'((HALF10_RAW < 1) ? 1 : HALF10_RAW);
  localparam logic [CW-1:0] HALF100_CNT = CW'((HALF100_RAW < 1) ? 1 : HALF100_RAW);

  // Bit positions of the synchronised reference-domain inputs
  localparam int SY_SPD = 0;
  localparam int SY_FDX = 1;
  localparam int SY_LNK = 2;
  localparam int SY_TRI = 3;
  localparam int SY_ACT = 4;
  localparam int SY_RTG = 5;
  localparam int SY_W   = 6;

  // Reset values
  localparam logic [3:0]    NIB_RST = 4'h0;
  localparam logic [CW-1:0] CNT_RST = 8'h00;

  // Line receive side, one word per line clock
  typedef struct packed {
    logic       act;
    logic       dat;
    logic       sos;
    logic       eos;
    logic       err;
    logic       fcar;
    logic [3:0] nib;
  } pmdp_line_rx_t;

  // Line transmit side
  typedef struct packed {
    logic       en;
    logic [3:0] nib;
  } pmdp_line_tx_t;

  typedef enum logic [1:0] {RX_IDLE, RX_LOCK, RX_FRAME} pmdp_rx_st_t;

endpackage

/* core/pmdp_sync3.sv */
// Three-stage synchroniser; output follows once stages two and three agree.
// Assumes d changes slower than three clk periods.
`timescale 1ns/10ps
module pmdp_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);
  wire  [W-1:0] q_d   = (s2_q & agree) | (q & ~agree);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= q_d;
    end
  end
endmodule

/* core/pmdp_clkgen.sv */
// MII clock divider with phase restart.
// Assumes half is at least one; rise marks the edge at which clk_q goes high.
`timescale 1ns/10ps
module pmdp_clkgen (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [pmdp_pkg::CW-1:0] half,
  input  wire logic                    realign,
  output logic                         clk_q,
  output logic                         rise
);
  logic [pmdp_pkg::CW-1:0] cnt_q;
  wire wrap = (cnt_q >= half - pmdp_pkg::CW'(1));
  wire [pmdp_pkg::CW-1:0] cnt_d = wrap ? pmdp_pkg::CNT_RST : cnt_q + pmdp_pkg::CW'(1);

  assign rise = wrap & ~clk_q & ~realign;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= pmdp_pkg::CNT_RST;
      clk_q <= 1'b0;
    end else if (realign) begin
      cnt_q <= pmdp_pkg::CNT_RST;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_q ^ wrap;
    end
  end
endmodule

/* core/pmdp_mii_path.sv */
// MII receive and transmit data path of a 10/100 PHY, facing the MAC.
// Assumes line-side logic on LINE_CLK and MAC logic on the generated MII clocks.
`timescale 1ns/10ps
// Summary of operation
// - At 10 Mb/s the receive clock runs at 2.5 MHz.
// - At 100 Mb/s the receive clock runs at 20 MHz.
// - At 10 Mb/s receive clock follows line data, keeps running after the stream.
// - At 100 Mb/s receive clock follows the link, else the reference clock.
// - At 10 Mb/s clock source changes between carrier sense and data valid.
// - At 100 Mb/s clock phase may jump while the link comes up.
// - At 10 Mb/s the receive clock realigns at each packet start and again after the frame end while activity stays up.
// - At 100 Mb/s the receive clock realigns only at link establishment.
// - Receive nibble bit 0 is least significant, bit 3 most.
// - While data valid, receive nibble changes on receive clock rising edges.
// - Data valid asserts only after the start delimiter is recovered.
// - Data valid drops after the end delimiter or a signal error.
// - Receive error and data valid change only with the receive clock.
// - At 10 Mb/s receive error is unused and stays low.
// - At 100 Mb/s receive error flags frame errors and false carrier.
// - Receive error is gated by the receive tristate control input.
// - Transmit clock is 2.5 MHz at 10 Mb/s, 20 MHz at 100 Mb/s.
// - Transmit nibble bit 0 is least significant, bit 3 most.
// - While transmit enable, nibbles are sampled on transmit clock rising edges.
// - On transmit enable, sampled nibbles are sent to the line.
// - After transmit enable drops, nothing more goes to the line.
// - Collision on receive activity during transmit; never in full duplex.
// - Carrier sense on receive or transmit in half duplex, receive only in full.
module pmdp_mii_path (
  input  wire logic                    REF_CLK,
  input  wire logic                    RST_N,
  input  wire logic                    LINE_CLK,
  input  wire logic                    SPEED_100,
  input  wire logic                    FULL_DUPLEX,
  input  wire logic                    LINK_UP,
  input  wire logic                    RECEIVE_TRISTATE_CONTROL,
  input  wire pmdp_pkg::pmdp_line_rx_t LINE_RX,
  output pmdp_pkg::pmdp_line_tx_t      LINE_TX,
  output logic                         RXCLK,
  output logic [3:0]                   RXD,
  output logic                         RXDV,
  output logic                         RXER,
  output logic                         RXER_OE_N,
  output logic                         TXCLK,
  input  wire logic                    TXEN,
  input  wire logic [3:0]              TXD,
  output logic                         COL,
  output logic                         CRS
);

  // Line domain: receive capture
  pmdp_pkg::pmdp_line_rx_t lrx_hold_q;
  logic                    lrx_tgl_q;
  logic                    lrx_act_q;
  wire lrx_evt = LINE_RX.dat | LINE_RX.sos | LINE_RX.eos | LINE_RX.err | LINE_RX.fcar;

  always_ff @(posedge LINE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lrx_hold_q <= '0;
      lrx_tgl_q  <= 1'b0;
      lrx_act_q  <= 1'b0;
    end else begin
      lrx_act_q <= LINE_RX.act;
      if (lrx_evt) begin
        lrx_hold_q <= LINE_RX;
        lrx_tgl_q  <= ~lrx_tgl_q;
      end
    end
  end

  // Reference domain: synchronised inputs
  logic [pmdp_pkg::SY_W-1:0] sy_q;
  wire  [pmdp_pkg::SY_W-1:0] sy_in = {lrx_tgl_q, lrx_act_q, RECEIVE_TRISTATE_CONTROL,
                                      LINK_UP, FULL_DUPLEX, SPEED_100};

  pmdp_sync3 #(.W(pmdp_pkg::SY_W)) u_sync_ref (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .d     (sy_in),
    .q     (sy_q)
  );

  wire spd_s = sy_q[pmdp_pkg::SY_SPD];
  wire fdx_s = sy_q[pmdp_pkg::SY_FDX];
  wire lnk_s = sy_q[pmdp_pkg::SY_LNK];
  wire tri_s = sy_q[pmdp_pkg::SY_TRI];
  wire act_s = sy_q[pmdp_pkg::SY_ACT];
  wire rtg_s = sy_q[pmdp_pkg::SY_RTG];

  // Clock rate selection
  wire [pmdp_pkg::CW-1:0] half_sel = spd_s ? pmdp_pkg::HALF100_CNT : pmdp_pkg::HALF10_CNT;

  // Receive event decode; held word is stable when the toggle is seen
  logic rx_seen_q;
  wire rx_evt  = rtg_s ^ rx_seen_q;
  wire ev_sos  = rx_evt & lrx_hold_q.sos;
  wire ev_dat  = rx_evt & lrx_hold_q.dat;
  wire ev_end  = rx_evt & (lrx_hold_q.eos | lrx_hold_q.err);
  wire ev_fcar = rx_evt & lrx_hold_q.fcar;

  // Receive framing state
  pmdp_pkg::pmdp_rx_st_t st_q;
  pmdp_pkg::pmdp_rx_st_t st_d;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      pmdp_pkg::RX_IDLE: begin
        if (act_s && CRS) begin
          st_d = pmdp_pkg::RX_LOCK;
        end
      end
      pmdp_pkg::RX_LOCK: begin
        if (ev_sos) begin
          st_d = pmdp_pkg::RX_FRAME;
        end else if (!act_s) begin
          st_d = pmdp_pkg::RX_IDLE;
        end
      end
      pmdp_pkg::RX_FRAME: begin
        if (ev_end) begin
          st_d = pmdp_pkg::RX_IDLE;
        end
      end
    endcase
  end

  wire in_frame = (st_q == pmdp_pkg::RX_FRAME);

  // Receive clock phase restart
  logic lnk_q;
  wire  lnk_rise = lnk_s & ~lnk_q;
  // Restart only once carrier sense is already up
  wire  pkt_lock = (st_q == pmdp_pkg::RX_IDLE) & act_s & CRS;
  wire  rx_realign = spd_s ? lnk_rise : pkt_lock;
  logic rx_tick;

  // Free-running between packets and without link
  pmdp_clkgen u_rxclk (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .half    (half_sel),
    .realign (rx_realign),
    .clk_q   (RXCLK),
    .rise    (rx_tick)
  );

  // Receive nibble holding and error pending
  logic       rxh_full_q;
  logic [3:0] rxh_nib_q;
  logic       err_pend_q;
  wire hold_set  = ev_dat & in_frame;
  wire rxh_full_d = hold_set | (rxh_full_q & ~rx_tick);
  wire err_set   = spd_s & ((rx_evt & lrx_hold_q.err & in_frame) | ev_fcar);
  wire err_pend_d = err_set | (err_pend_q & ~rx_tick);
  wire rxdv_d    = rxh_full_q | (RXDV & in_frame);
  wire rxer_d    = err_pend_q & spd_s & ~tri_s;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_seen_q  <= 1'b0;
      st_q       <= pmdp_pkg::RX_IDLE;
      lnk_q      <= 1'b0;
      rxh_full_q <= 1'b0;
      rxh_nib_q  <= pmdp_pkg::NIB_RST;
      err_pend_q <= 1'b0;
    end else begin
      rx_seen_q  <= rtg_s;
      st_q       <= st_d;
      lnk_q      <= lnk_s;
      rxh_full_q <= rxh_full_d;
      err_pend_q <= err_pend_d;
      if (hold_set) begin
        rxh_nib_q <= lrx_hold_q.nib;
      end
    end
  end

  // MII receive outputs; RXD, RXDV and RXER updated only at the rising edge of RXCLK, RXER_OE_N every cycle
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RXD       <= pmdp_pkg::NIB_RST;
      RXDV      <= 1'b0;
      RXER      <= 1'b0;
      RXER_OE_N <= 1'b1;
    end else begin
      RXER_OE_N <= tri_s;
      if (rx_tick) begin
        RXDV <= rxdv_d;
        RXER <= rxer_d;
        if (rxh_full_q) begin
          RXD <= rxh_nib_q;
        end
      end
    end
  end

  // Transmit clock and sampling
  logic tx_tick;

  pmdp_clkgen u_txclk (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .half    (half_sel),
    .realign (1'b0),
    .clk_q   (TXCLK),
    .rise    (tx_tick)
  );

  logic                    tx_en_q;
  logic                    tx_tgl_q;
  pmdp_pkg::pmdp_line_tx_t tx_slot_q [2];
  wire                     tx_send = tx_tick & (TXEN | tx_en_q);
  wire                     tx_tgl_d = ~tx_tgl_q;
  wire [3:0]               tx_nib = TXEN ? TXD : pmdp_pkg::NIB_RST;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_en_q      <= 1'b0;
      tx_tgl_q     <= 1'b0;
      tx_slot_q[0] <= '0;
      tx_slot_q[1] <= '0;
    end else begin
      if (tx_tick) begin
        tx_en_q <= TXEN;
      end
      if (tx_send) begin
        tx_tgl_q            <= tx_tgl_d;
        tx_slot_q[tx_tgl_d] <= '{en: TXEN, nib: tx_nib};
      end
    end
  end

  // Carrier sense and collision
  wire col_d = act_s & tx_en_q & ~fdx_s;
  wire crs_d = act_s | (tx_en_q & ~fdx_s);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      COL <= 1'b0;
      CRS <= 1'b0;
    end else begin
      COL <= col_d;
      CRS <= crs_d;
    end
  end

  // Line domain: transmit delivery; slots alternate so a word outlives the crossing
  logic ltx_tgl_s;
  logic ltx_seen_q;

  pmdp_sync3 #(.W(1)) u_sync_line (
    .clk   (LINE_CLK),
    .rst_n (RST_N),
    .d     (tx_tgl_q),
    .q     (ltx_tgl_s)
  );

  wire ltx_evt = ltx_tgl_s ^ ltx_seen_q;

  always_ff @(posedge LINE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ltx_seen_q <= 1'b0;
      LINE_TX    <= '0;
    end else begin
      ltx_seen_q <= ltx_tgl_s;
      if (ltx_evt) begin
        LINE_TX <= tx_slot_q[ltx_tgl_s];
      end
    end
  end

  // Checks
  a_col_full_low: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    fdx_s |=> !COL) else $error("collision seen in full duplex");

  a_crs_tx_half: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (tx_en_q && !fdx_s) |=> CRS) else $error("carrier sense missing on half duplex transmit");

  a_crs_full_rx: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (fdx_s && !act_s) |=> !CRS) else $error("carrier sense without receive in full duplex");

  a_rxer_ten_low: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (rx_tick && !spd_s) |=> !RXER) else $error("receive error raised at 10 Mb/s");

  a_rxer_tri_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (rx_tick && tri_s) |=> (!RXER && RXER_OE_N)) else $error("receive error not gated");

  a_rx_sync_edge: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !$stable({RXD, RXDV, RXER}) |-> $rose(RXCLK)) else $error("receive output moved off clock edge");

  a_rxdv_after_sos: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(RXDV) |-> $past(in_frame)) else $error("data valid before start delimiter");

  a_rxdv_end_drop: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (in_frame && ev_end) |-> ##[1:40] !RXDV) else $error("data valid held after frame end");

  a_tx_sample_en: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    tx_tick |=> (tx_en_q == $past(TXEN))) else $error("transmit enable not sampled");

  a_txclk_ten_rate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ($rose(TXCLK) && !spd_s && !$past(spd_s)) |-> ##1 (TXCLK || spd_s)[*7] ##1 (!TXCLK || spd_s))
    else $error("transmit clock high time wrong at 10 Mb/s");

  a_rx_realign_pkt: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (!spd_s && $rose(in_frame)) |-> !rx_realign) else $error("receive clock realigned inside frame");

  a_line_tx_stop: assert property (@(posedge LINE_CLK) disable iff (!RST_N)
    (ltx_evt && !tx_slot_q[ltx_tgl_s].en) |=> !LINE_TX.en) else $error("line transmit not stopped");

  a_line_tx_data: assert property (@(posedge LINE_CLK) disable iff (!RST_N)
    (ltx_evt && tx_slot_q[ltx_tgl_s].en) |=> LINE_TX.en) else $error("line transmit not started");

  a_rx_realign_crs: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (!spd_s && rx_realign) |-> CRS) else $error("receive clock restarted before carrier sense");

  a_rx_realign_link: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (spd_s && rx_realign) |-> (lnk_s && !lnk_q)) else $error("receive clock restarted without link rise");

  a_rxd_hold_idle: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (RXDV && !rx_tick) |=> $stable(RXD)) else $error("receive nibble moved between clock edges");

  a_rxer_err_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (rx_tick && spd_s && !tri_s && err_pend_q) |=> RXER) else $error("receive error not raised at 100 Mb/s");

  a_txclk_hund_rate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (spd_s && $past(spd_s) && $rose(TXCLK)) |=> (!TXCLK || !spd_s))
    else $error("transmit clock high time wrong at 100 Mb/s");

  a_rxclk_hund_rate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (spd_s && $past(spd_s) && $rose(RXCLK)) |=> (!RXCLK || !spd_s))
    else $error("receive clock high time wrong at 100 Mb/s");

  c_rx_frame: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(RXDV) ##[1:400] $fell(RXDV));

  c_rx_false_car: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    spd_s && $rose(RXER) && !RXDV);

  c_collision: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(COL));

  c_pkt_realign: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    !spd_s && rx_realign);

endmodule

/* bench/pmdp_mac_model.sv */
// MAC-side model of the MII: sends nibble frames and captures received nibbles.
// Assumes TXCLK and RXCLK come from the PHY; launches just after TXCLK rising edges.
`timescale 1ns/10ps
module pmdp_mac_model (
  input  wire logic        TXCLK,
  input  wire logic        RXCLK,
  input  wire logic [3:0]  RXD,
  input  wire logic        RXDV,
  input  wire logic        RXER,
  input  wire logic        tx_go,
  input  wire logic [15:0] tx_frame,
  output logic             TXEN,
  output logic [3:0]       TXD,
  output logic [15:0]      rx_word,
  output int               rx_cnt,
  output int               er_cnt
);
  int   tx_left;
  logic go_q;

  initial begin
    TXEN = 1'b0;
    TXD = 4'h0;
    tx_left = 0;
    go_q = 1'b0;
    forever begin
      @(posedge TXCLK);
      #1;
      // A frame starts at the first TXCLK edge that sees a new request
      if (tx_go && !go_q) begin
        tx_left = 4;
      end
      go_q = tx_go;
      if (tx_left > 0) begin
        TXEN = 1'b1;
        TXD = tx_frame[4*tx_left-1 -: 4];
        tx_left--;
      end else begin
        TXEN = 1'b0;
        // Idle nibble keeps changing so a stale value is never mistaken for data
        TXD = ~TXD;
      end
    end
  end

  // Mid-period sampling, each new nibble taken once
  initial begin
    rx_word = 16'h0000;
    rx_cnt = 0;
    er_cnt = 0;
    forever begin
      @(negedge RXCLK);
      if (RXER === 1'b1) er_cnt++;
      if (RXDV === 1'b1 && RXD !== rx_word[3:0]) begin
        rx_word = {rx_word[11:0], RXD};
        rx_cnt++;
      end
    end
  end
endmodule

/* bench/pmdp_mii_path_bench.sv */
// Self-checking bench of the MII data path; line side driven here, MAC side by the model.
// Assumes REF_CLK at 40 MHz and a free line clock of 125 ns in no phase relation.
`timescale 1ns/10ps
module pmdp_mii_path_bench;
  logic                    ref_clk = 1'b0;
  logic                    line_clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    spd = 1'b0;
  logic                    fdx = 1'b0;
  logic                    lnk = 1'b1;
  logic                    tri_c = 1'b0;
  logic                    tx_go = 1'b0;
  logic [15:0]             tx_frame = 16'h0000;
  pmdp_pkg::pmdp_line_rx_t line_rx = '0;
  pmdp_pkg::pmdp_line_tx_t line_tx;
  logic                    rxclk, rxdv, rxer, rxer_oe_n, txclk, txen, col, crs;
  logic [3:0]              rxd, txd;
  logic [15:0]             rx_word;
  logic [15:0]             tx_word = 16'h0000;
  int                      rx_cnt, er_cnt;
  int                      tx_cnt = 0;
  int                      fail_count = 0;
  int                      num_checks = 0;
  int                      cyc = 0;

  always #12.5 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #62.5 line_clk = ~line_clk;
  end

  pmdp_mii_path i_pmdp_mii_path (
    .REF_CLK(ref_clk), .RST_N(rst_n), .LINE_CLK(line_clk), .SPEED_100(spd), .FULL_DUPLEX(fdx),
    .LINK_UP(lnk), .RECEIVE_TRISTATE_CONTROL(tri_c), .LINE_RX(line_rx), .LINE_TX(line_tx),
    .RXCLK(rxclk), .RXD(rxd), .RXDV(rxdv), .RXER(rxer), .RXER_OE_N(rxer_oe_n), .TXCLK(txclk),
    .TXEN(txen), .TXD(txd), .COL(col), .CRS(crs)
  );

  pmdp_mac_model i_pmdp_mac_model (
    .TXCLK(txclk), .RXCLK(rxclk), .RXD(rxd), .RXDV(rxdv), .RXER(rxer), .tx_go(tx_go),
    .tx_frame(tx_frame), .TXEN(txen), .TXD(txd), .rx_word(rx_word), .rx_cnt(rx_cnt), .er_cnt(er_cnt)
  );

  // Line transmit monitor, each new nibble taken once
  always @(posedge line_clk) begin
    if (line_tx.en === 1'b1 && line_tx.nib !== tx_word[3:0]) begin
      tx_word <= {tx_word[11:0], line_tx.nib};
      tx_cnt <= tx_cnt + 1;
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      finish_test;
    end
  end

  task automatic finish_test;
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Flags are {dat, sos, eos, err, fcar}, one line cycle long
  task automatic lev(input logic [4:0] f, input logic [3:0] n, input int g);
    repeat (g) @(posedge line_clk);
    #1;
    line_rx <= pmdp_pkg::pmdp_line_rx_t'({line_rx.act, f, n});
    @(posedge line_clk);
    #1;
    line_rx <= pmdp_pkg::pmdp_line_rx_t'({line_rx.act, 5'h00, n});
  endtask

  task automatic set_act(input logic v);
    @(posedge line_clk);
    #1;
    line_rx.act <= v;
    repeat (2) @(posedge line_clk);
  endtask

  task automatic pin_step;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic period(output logic [15:0] tp, output logic [15:0] rp);
    time t0;
    @(posedge txclk);
    t0 = $time;
    @(posedge txclk);
    tp = 16'($time - t0);
    @(posedge rxclk);
    t0 = $time;
    @(posedge rxclk);
    rp = 16'($time - t0);
  endtask

  task automatic t_rx10;
    logic [3:0] nibs [4];
    nibs = '{4'ha, 4'h5, 4'hc, 4'h3};
    set_act(1'b1);
    check(crs, 1'b1);
    lev(5'h10, 4'h6, 1);
    repeat (6) @(posedge line_clk);
    check(rxdv, 1'b0);
    check(16'(rx_cnt), 16'd0);
    lev(5'h08, 4'h0, 1);
    for (int i = 0; i < 4; i++) begin
      lev(5'h10, nibs[i], 3);
    end
    lev(5'h04, 4'h0, 3);
    set_act(1'b0);
    repeat (8) @(posedge line_clk);
    check(rxdv, 1'b0);
    check(rx_word, 16'ha5c3);
    check(16'(rx_cnt), 16'd4);
    lev(5'h02, 4'h0, 2);
    lev(5'h01, 4'h0, 2);
    repeat (8) @(posedge line_clk);
    check(16'(er_cnt), 16'd0);
  endtask

  task automatic t_tx;
    pin_step;
    tx_frame = 16'h1234;
    tx_go = 1'b1;
    repeat (2) @(posedge txclk);
    #1;
    tx_go = 1'b0;
    repeat (8) @(posedge txclk);
    repeat (8) @(posedge line_clk);
    #1;
    check(tx_word, 16'h1234);
    check(16'(tx_cnt), 16'd4);
    check(line_tx, 5'h00);
  endtask

  task automatic t_col(input logic fd);
    pin_step;
    fdx = fd;
    tx_frame = 16'h8765;
    tx_go = 1'b1;
    repeat (2) @(posedge txclk);
    #1;
    tx_go = 1'b0;
    set_act(1'b1);
    check(col, !fd);
    check(crs, 1'b1);
    set_act(1'b0);
    check(crs, !fd);
    check(col, 1'b0);
    repeat (8) @(posedge txclk);
  endtask

  task automatic t_rx100;
    set_act(1'b1);
    lev(5'h08, 4'h0, 1);
    lev(5'h10, 4'h9, 1);
    lev(5'h02, 4'h0, 1);
    set_act(1'b0);
    repeat (4) @(posedge line_clk);
    check(rx_word[3:0], 4'h9);
    check(16'(er_cnt), 16'd1);
    check(rxdv, 1'b0);
    check(rxer_oe_n, 1'b0);
    lev(5'h01, 4'h0, 2);
    repeat (4) @(posedge line_clk);
    check(16'(er_cnt), 16'd2);
    pin_step;
    tri_c = 1'b1;
    repeat (10) pin_step;
    check(rxer_oe_n, 1'b1);
    lev(5'h01, 4'h0, 2);
    repeat (4) @(posedge line_clk);
    check(16'(er_cnt), 16'd2);
  endtask

  initial begin
    logic [15:0] tp;
    logic [15:0] rp;
    repeat (8) @(posedge ref_clk);
    check(rxdv, 1'b0);
    check(rxer_oe_n, 1'b1);
    check({col, crs}, 2'b00);
    check(line_tx, 5'h00);
    #1;
    rst_n = 1'b1;
    repeat (10) pin_step;
    period(tp, rp);
    check(tp, 16'd400);
    check(rp, 16'd400);
    t_rx10;
    t_tx;
    t_col(1'b0);
    t_col(1'b1);
    pin_step;
    spd = 1'b1;
    repeat (10) pin_step;
    // Link drop and return restarts the receive clock once
    lnk = 1'b0;
    repeat (10) pin_step;
    lnk = 1'b1;
    repeat (10) pin_step;
    period(tp, rp);
    check(tp, 16'd50);
    check(rp, 16'd50);
    t_rx100;
    finish_test;
  end
endmodule
